// >>> bpa_pkg.sv
/*
 * Constants for the backplane input bit alignment block.
 * Assumes one clock period equals one quarter of a backplane bit.
 */
// Operation
// - Thirty-two delay registers, one per stream
// - 32 Mbps mode uses registers 0 to 15
// - Five-bit delay field resets to zero
// - Mode low samples at three-quarter point
// - Mode low delays field quarters
// - Mode high bits 1:0 pick sample point
// - Mode high bits 4:2 give whole bits
// - One shared sampling-mode bit
package bpa_pkg;
    localparam int             NUM_STREAMS = 32;
    localparam int             NUM_32M     = 16;
    localparam int             DW          = 16;
    localparam int             AW          = 16;
    localparam int             FW          = 5;
    localparam int             QW          = 6;
    localparam logic [AW-1:0]  ADDR_FIRST  = 16'h0063;
    localparam logic [AW-1:0]  ADDR_LAST   = 16'h0082;
    localparam logic [DW-1:0]  REG_RESET   = 16'h0000;
    localparam logic [1:0]     QPB_LAST    = 2'h3;
    localparam logic [QW-1:0]  SAMPLE_34   = 6'h03;
    localparam logic [QW-1:0]  MAX_Q       = 6'h23;
    localparam int             HIST_LEN    = 36;
    localparam logic [1:0]     EMIT_PHASE  = 2'h3;
    localparam logic [5:0]     WARM_DONE   = 6'h28;

    // Sample point code in the high mode, as quarters into the bit
    function automatic logic [QW-1:0] bpa_point(input logic [1:0] code);
        logic [QW-1:0] q;
        q = 6'h03;
        unique case (code)
            2'h0: q = 6'h03;
            2'h1: q = 6'h04;
            2'h2: q = 6'h01;
            2'h3: q = 6'h02;
        endcase
        return q;
    endfunction
endpackage

// >>> bpa_lane_if.sv
/*
 * Per-stream lane between the register side and an aligner.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface bpa_lane_if;
    import bpa_pkg::*;
    logic          bit_in;
    logic [FW-1:0] delay;
    logic          mode;
    logic          emit;
    logic          active;
    logic          bit_out;

    modport ctrl (output bit_in, delay, mode, emit, active, input bit_out);
    modport lane (input bit_in, delay, mode, emit, active, output bit_out);
endinterface

// >>> bpa_aligner.sv
/*
 * One backplane stream aligner: a quarter-bit history line and a tap.
 * Assumes bit_in is already synchronised and emit pulses once per bit.
 */
`timescale 1ns/1ps
module bpa_aligner (
    input wire logic clock,
    input wire logic resetn,
    bpa_lane_if.lane ln
);
    import bpa_pkg::*;

    logic [HIST_LEN-1:0] hist_ff;
    logic [HIST_LEN-1:0] nxt_hist;
    logic                out_ff;
    logic                nxt_out;
    logic [QW-1:0]       dq;
    logic [5:0]          warm_ff;
    logic [5:0]          nxt_warm;

    // Total quarters from bit boundary to the sampling instant
    always_comb begin
        if (ln.mode) begin
            dq = {1'b0, ln.delay[4:2], 2'h0} + bpa_point(ln.delay[1:0]);
        end else begin
            dq = {1'b0, ln.delay} + SAMPLE_34;
        end
    end

    // Fixed latency of MAX_Q quarters lets a later tap stand for an earlier sample
    always_comb begin
        nxt_hist = {hist_ff[HIST_LEN-2:0], ln.bit_in};
        nxt_out  = out_ff;
        nxt_warm = (warm_ff == WARM_DONE) ? warm_ff : warm_ff + 6'h01;
        if (!ln.active) begin
            nxt_out = 1'b0;
        end else if (ln.emit) begin
            nxt_out = hist_ff[MAX_Q - dq];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            hist_ff <= '0;
            out_ff  <= 1'b0;
            warm_ff <= 6'h00;
        end else begin
            hist_ff <= nxt_hist;
            out_ff  <= nxt_out;
            warm_ff <= nxt_warm;
        end
    end

    assign ln.bit_out = out_ff;

    logic warm;
    assign warm = (warm_ff == WARM_DONE);

    AST_LOW_ZERO: assert property (@(posedge clock) disable iff (!resetn)
        warm && $past(ln.emit && ln.active && !ln.mode && ln.delay == 5'h00)
        |-> out_ff == $past(ln.bit_in, 34))
        else $error("low mode zero delay sample wrong");
    AST_LOW_MAX: assert property (@(posedge clock) disable iff (!resetn)
        warm && $past(ln.emit && ln.active && !ln.mode && ln.delay == 5'h1F)
        |-> out_ff == $past(ln.bit_in, 3))
        else $error("low mode max delay sample wrong");
    AST_HIGH_POINT: assert property (@(posedge clock) disable iff (!resetn)
        warm && $past(ln.emit && ln.active && ln.mode && ln.delay == 5'h01)
        |-> out_ff == $past(ln.bit_in, 33))
        else $error("high mode 4/4 point wrong");
    AST_HIGH_INT: assert property (@(posedge clock) disable iff (!resetn)
        warm && $past(ln.emit && ln.active && ln.mode && ln.delay == 5'h1E)
        |-> out_ff == $past(ln.bit_in, 8))
        else $error("high mode integer delay wrong");
    AST_IDLE: assert property (@(posedge clock) disable iff (!resetn)
        $past(!ln.active) |-> !out_ff)
        else $error("inactive lane output not low");
endmodule

// >>> bpa_bit_delay.sv
/*
 * Backplane input bit delay block: thirty-two delay registers on the
 * processor port, and one aligner per backplane input stream.
 * Assumes cpu strobes come from logic on this clock, stream pins are
 * asynchronous, and one clock period is one quarter bit.
 */
`timescale 1ns/1ps
module bpa_bit_delay (
    input  wire logic                            clock,
    input  wire logic                            resetn,
    input  wire logic                            cpu_cs_n,
    input  wire logic                            cpu_wr,
    input  wire logic                            cpu_rd,
    input  wire logic [bpa_pkg::AW-1:0]          cpu_addr,
    input  wire logic [bpa_pkg::DW-1:0]          cpu_wdata,
    output logic      [bpa_pkg::DW-1:0]          cpu_rdata,
    output logic                                 cpu_ack,
    input  wire logic                            sample_point_select_mode,
    input  wire logic                            bp_32m_mode,
    input  wire logic [bpa_pkg::NUM_STREAMS-1:0] bp_in,
    output logic      [bpa_pkg::NUM_STREAMS-1:0] bp_rx_bit,
    output logic                                 bp_rx_strobe
);
    import bpa_pkg::*;

    // Register file, indexed by address minus the first offset
    logic [DW-1:0] regs_ff [NUM_STREAMS];
    logic [DW-1:0] nxt_regs [NUM_STREAMS];
    logic [DW-1:0] rdata_ff;
    logic [DW-1:0] nxt_rdata;
    logic          ack_ff;
    logic          nxt_ack;

    // Bus decode
    logic          hit;
    logic [AW-1:0] offs;
    logic [4:0]    idx;
    logic          wr_go;
    logic          rd_go;

    // Quarter-bit phase and per-bit strobe
    logic [1:0]    qph_ff;
    logic [1:0]    nxt_qph;
    logic          strobe_ff;
    logic          nxt_strobe;
    logic          emit;

    // Pin synchronisers
    logic [NUM_STREAMS-1:0] s1_ff;
    logic [NUM_STREAMS-1:0] s2_ff;
    logic [NUM_STREAMS-1:0] s3_ff;
    logic [NUM_STREAMS-1:0] clean_ff;
    logic [NUM_STREAMS-1:0] nxt_clean;

    // Address decode; the window is contiguous so a range compare suffices
    always_comb begin
        offs  = cpu_addr - ADDR_FIRST;
        idx   = offs[4:0];
        hit   = (cpu_addr >= ADDR_FIRST) && (cpu_addr <= ADDR_LAST);
        wr_go = !cpu_cs_n && cpu_wr && hit;
        rd_go = !cpu_cs_n && cpu_rd;
    end

    // Register writes store all sixteen bits, reserved ones included
    always_comb begin
        for (int i = 0; i < NUM_STREAMS; i++) begin
            nxt_regs[i] = regs_ff[i];
        end
        if (wr_go) begin
            nxt_regs[idx] = cpu_wdata;
        end
    end

    always_ff @(posedge clock) begin
        for (int i = 0; i < NUM_STREAMS; i++) begin
            if (!resetn) begin
                regs_ff[i] <= REG_RESET;
            end else begin
                regs_ff[i] <= nxt_regs[i];
            end
        end
    end

    // Read path; unmapped addresses read zero
    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_ack   = 1'b0;
        if (rd_go) begin
            nxt_ack = 1'b1;
            if (hit) begin
                nxt_rdata = regs_ff[idx];
            end else begin
                nxt_rdata = REG_RESET;
            end
        end else if (!cpu_cs_n && cpu_wr) begin
            nxt_ack = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            rdata_ff <= REG_RESET;
            ack_ff   <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            ack_ff   <= nxt_ack;
        end
    end

    assign cpu_rdata = rdata_ff;
    assign cpu_ack   = ack_ff;

    // Free-running quarter counter; emit marks the last quarter of a bit
    always_comb begin
        nxt_qph    = qph_ff + 2'h1;
        emit       = (qph_ff == EMIT_PHASE);
        nxt_strobe = emit;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            qph_ff    <= 2'h0;
            strobe_ff <= 1'b0;
        end else begin
            qph_ff    <= nxt_qph;
            strobe_ff <= nxt_strobe;
        end
    end

    assign bp_rx_strobe = strobe_ff;

    // A change is taken only when stages two and three agree,
    // which rejects a single metastable sample at the cost of a cycle
    always_comb begin
        for (int i = 0; i < NUM_STREAMS; i++) begin
            nxt_clean[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : clean_ff[i];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            s1_ff    <= '0;
            s2_ff    <= '0;
            s3_ff    <= '0;
            clean_ff <= '0;
        end else begin
            s1_ff    <= bp_in;
            s2_ff    <= s1_ff;
            s3_ff    <= s2_ff;
            clean_ff <= nxt_clean;
        end
    end

    // One aligner per stream; all share the mode bit and the bit strobe
    for (genvar g = 0; g < NUM_STREAMS; g++) begin : g_lane
        bpa_lane_if lane ();

        assign lane.bit_in = clean_ff[g];
        assign lane.delay  = regs_ff[g][FW-1:0];
        assign lane.mode   = sample_point_select_mode;
        assign lane.emit   = emit;
        // Upper half idles when the backplane runs at 32 Mbps
        assign lane.active = !bp_32m_mode || (g < NUM_32M);

        bpa_aligner bpa_aligner_i (
            .clock  (clock),
            .resetn (resetn),
            .ln     (lane.lane)
        );

        assign bp_rx_bit[g] = lane.bit_out;
    end

    // Checks on the register side and the stream timing

    AST_WRITE_READ: assert property (@(posedge clock) disable iff (!resetn)
        (!cpu_cs_n && cpu_wr && !cpu_rd && hit)
        ##1 (!cpu_cs_n && cpu_rd && !cpu_wr && cpu_addr == $past(cpu_addr))
        |=> cpu_rdata == $past(cpu_wdata, 2) && cpu_ack)
        else $error("readback differs from last write");

    AST_UNMAPPED: assert property (@(posedge clock) disable iff (!resetn)
        (!cpu_cs_n && cpu_rd && !hit) |=> cpu_rdata == REG_RESET)
        else $error("unmapped read not zero");

    AST_RESET_VAL: assert property (@(posedge clock)
        $rose(resetn) |-> regs_ff[0] == REG_RESET && regs_ff[31] == REG_RESET)
        else $error("register not zero after reset");

    AST_UPPER_IDLE: assert property (@(posedge clock) disable iff (!resetn)
        bp_32m_mode [*2] |-> bp_rx_bit[NUM_STREAMS-1:NUM_32M] == '0)
        else $error("upper streams active in 32 Mbps mode");

    AST_STROBE_PERIOD: assert property (@(posedge clock) disable iff (!resetn)
        bp_rx_strobe |=> !bp_rx_strobe [*3] ##1 bp_rx_strobe)
        else $error("bit strobe not once per four quarters");

    // Unmapped writes alias onto an index too, so they must leave it alone
    AST_NO_STRAY_WRITE: assert property (@(posedge clock) disable iff (!resetn)
        (cpu_cs_n || !cpu_wr || cpu_addr < ADDR_FIRST || cpu_addr > ADDR_LAST)
        |=> regs_ff[$past(idx)] == $past(regs_ff[idx]))
        else $error("register changed without a write");

    AST_FIRST_STROBE: assert property (@(posedge clock)
        $rose(resetn) |-> !bp_rx_strobe ##4 bp_rx_strobe)
        else $error("first bit strobe not four clocks after reset");

    AST_ACK_PULSE: assert property (@(posedge clock) disable iff (!resetn)
        cpu_ack == $past(!cpu_cs_n && (cpu_rd || cpu_wr)))
        else $error("ack not one cycle after a selected access");

    // Outside a strobe only a lane going idle may move its output
    AST_OUT_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        !bp_rx_strobe && !$past(bp_32m_mode) |-> $stable(bp_rx_bit))
        else $error("stream output changed between strobes");

    COV_LOW_MODE: cover property (@(posedge clock) disable iff (!resetn)
        !sample_point_select_mode && bp_rx_strobe && bp_rx_bit[0]);
    COV_HIGH_MODE: cover property (@(posedge clock) disable iff (!resetn)
        sample_point_select_mode && bp_rx_strobe && bp_rx_bit[5]);
    COV_MODE_32M: cover property (@(posedge clock) disable iff (!resetn)
        bp_32m_mode && bp_rx_strobe && bp_rx_bit[15]);
    COV_WRITE_TOP: cover property (@(posedge clock) disable iff (!resetn)
        wr_go && cpu_addr == ADDR_LAST);
    COV_BACK_TO_BACK: cover property (@(posedge clock) disable iff (!resetn)
        wr_go ##1 rd_go);
endmodule

// >>> bpa_stream_src.sv
/*
 * Far-side model: thirty-two free-running backplane serial streams.
 * Assumes one bit lasts four clocks; the pins change on the falling edge.
 */
`timescale 1ns/1ps
module bpa_stream_src (
    input wire logic    clock,
    output logic [31:0] bp_in
);
    logic [31:0] pat_ff = 32'h1357_9BDF;
    logic [1:0]  ph_ff  = 2'h0;

    // New bit every fourth clock; the mix keeps only streams 0 and 31 from being plain shifted copies
    always @(negedge clock) begin
        ph_ff <= ph_ff + 2'h1;
        if (ph_ff == 2'h3) begin
            pat_ff <= {pat_ff[30:0], pat_ff[31] ^ pat_ff[21] ^ pat_ff[1]} ^ {pat_ff[0], 31'h0};
        end
    end
    assign bp_in = pat_ff;
endmodule

// >>> tb_bpa_bit_delay.sv
/*
 * Testbench for the backplane input bit delay block.
 * Assumes the stream model above; expectations come from a pin history.
 */
`timescale 1ns/1ps
module tb_bpa_bit_delay;
    import bpa_pkg::*;
    logic                   clock = 1'b0;
    logic                   resetn = 1'b0;
    logic                   cpu_cs_n = 1'b1;
    logic                   cpu_wr = 1'b0;
    logic                   cpu_rd = 1'b0;
    logic [AW-1:0]          cpu_addr = 16'h0000;
    logic [DW-1:0]          cpu_wdata = 16'h0000;
    logic [DW-1:0]          cpu_rdata;
    logic                   cpu_ack;
    logic                   mode = 1'b0;
    logic                   m32 = 1'b0;
    logic [NUM_STREAMS-1:0] bp_in;
    logic [NUM_STREAMS-1:0] bp_rx_bit;
    logic                   bp_rx_strobe;
    logic [NUM_STREAMS-1:0] hist [0:5999];
    int                     pq [4] = '{3, 4, 1, 2};
    int                     cyc = 0;
    int                     error_cnt = 0;
    int                     n_checks = 0;

    always #50 clock = ~clock;

    bpa_bit_delay bpa_bit_delay_i (.clock(clock), .resetn(resetn), .cpu_cs_n(cpu_cs_n),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .sample_point_select_mode(mode),
        .bp_32m_mode(m32), .bp_in(bp_in), .bp_rx_bit(bp_rx_bit), .bp_rx_strobe(bp_rx_strobe));
    bpa_stream_src bpa_stream_src_i (.clock(clock), .bp_in(bp_in));

    // Pin history for the reference; the ceiling is far above the run's length
    always @(posedge clock) begin
        hist[cyc] = bp_in;
        cyc = cyc + 1;
        if (cyc == 6000) begin
            error_cnt++;
            results();
        end
    end

    task automatic results();
        $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cmp_w(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_v(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One access: taken at the rising edge, ack stands in the following cycle
    task automatic acc(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] wd,
                       output logic [DW-1:0] rd);
        @(negedge clock);
        cpu_cs_n = 1'b0;
        cpu_wr = w;
        cpu_rd = ~w;
        cpu_addr = a;
        cpu_wdata = wd;
        @(posedge clock);
        @(negedge clock);
        cpu_cs_n = 1'b1;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        cmp_w("cpu_ack", 16'h0001, {15'h0000, cpu_ack});
        rd = cpu_rdata;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        logic [DW-1:0] r;
        acc(1'b1, a, d, r);
    endtask

    task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        logic [DW-1:0] r;
        acc(1'b0, a, 16'h0000, r);
        cmp_w("cpu_rdata", exp, r);
    endtask

    task automatic t_reset();
        for (int n = 0; n < NUM_STREAMS; n++) begin
            rchk(ADDR_FIRST + 16'(n), 16'h0000);
        end
        rchk(16'h0062, 16'h0000);
        rchk(16'h0083, 16'h0000);
        $display("Test reset values done");
    endtask

    // Reserved bits set too: they must read back as written
    task automatic t_regs();
        for (int n = 0; n < NUM_STREAMS; n++) begin
            wr(ADDR_FIRST + 16'(n), 16'hA5E0 ^ 16'(n));
        end
        for (int n = 0; n < NUM_STREAMS; n++) begin
            rchk(ADDR_FIRST + 16'(n), 16'hA5E0 ^ 16'(n));
        end
        wr(16'h0083, 16'hFFFF);
        rchk(16'h0083, 16'h0000);
        rchk(ADDR_LAST, 16'hA5FF);
        $display("Test register access done");
    endtask

    // Every field code across the streams; delay in quarters taken from the history
    task automatic t_stream(input logic md, input logic m, input logic [4:0] xr);
        logic [4:0]             f [NUM_STREAMS];
        logic [NUM_STREAMS-1:0] exp;
        int                     d;
        int                     b;
        for (int n = 0; n < NUM_STREAMS; n++) begin
            f[n] = 5'(n) ^ xr;
            wr(ADDR_FIRST + 16'(n), {11'h000, f[n]});
        end
        @(negedge clock);
        mode = md;
        m32 = m;
        repeat (48) @(negedge clock);
        for (int k = 0; k < 8; k++) begin
            b = 0;
            while (bp_rx_strobe !== 1'b1 && b < 8) begin
                @(negedge clock);
                b++;
            end
            if (k > 0) cmp_w("strobe spacing", 16'h0003, 16'(b));
            // Pin to tap: four sync edges plus a 36-quarter line, one edge before cyc
            for (int n = 0; n < NUM_STREAMS; n++) begin
                d = md ? 4 * f[n][4:2] + pq[f[n][1:0]] : f[n] + 3;
                exp[n] = (m && n >= NUM_32M) ? 1'b0 : hist[cyc - 41 + d][n];
            end
            cmp_v("bp_rx_bit", exp, bp_rx_bit);
            @(negedge clock);
        end
        $display("Test stream mode %0d m32 %0d done", md, m);
    endtask

    // Write then read the same register on consecutive edges
    task automatic t_b2b();
        @(negedge clock);
        cpu_cs_n = 1'b0;
        cpu_wr = 1'b1;
        cpu_rd = 1'b0;
        cpu_addr = ADDR_FIRST + 16'h0005;
        cpu_wdata = 16'h0C3A;
        @(negedge clock);
        cmp_w("cpu_ack", 16'h0001, {15'h0000, cpu_ack});
        cpu_wr = 1'b0;
        cpu_rd = 1'b1;
        @(negedge clock);
        cpu_cs_n = 1'b1;
        cpu_rd = 1'b0;
        cmp_w("cpu_rdata", 16'h0C3A, cpu_rdata);
        $display("Test back-to-back access done");
    endtask

    // Reset in mid-run must clear registers written earlier
    task automatic t_midreset();
        @(negedge clock);
        resetn = 1'b0;
        repeat (2) @(negedge clock);
        cmp_w("cpu_rdata", 16'h0000, cpu_rdata);
        cmp_w("bp_rx_strobe", 16'h0000, {15'h0000, bp_rx_strobe});
        cmp_v("bp_rx_bit", 32'h0000_0000, bp_rx_bit);
        resetn = 1'b1;
        t_reset();
        $display("Test mid-run reset done");
    endtask

    initial begin
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        t_reset();
        t_regs();
        t_b2b();
        t_midreset();
        t_stream(1'b0, 1'b0, 5'h00);
        t_stream(1'b1, 1'b0, 5'h1F);
        t_stream(1'b1, 1'b1, 5'h0A);
        t_stream(1'b0, 1'b1, 5'h15);
        results();
    end
endmodule
